// ==== bench/irq_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// host system stand-in
// ------------------------------------------------------------
module irq_host_model
    import irq_agg_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // requests from host-side devices
    input  wire logic [HOST_SRC_N-1:0] hostReq,
    output logic      [HOST_SRC_N-1:0] hostSrc,
    // host interrupt input
    input  wire logic                  host_irq_out_pin,
    output logic                       hostIrqSeen
);
    always_ff @(posedge clk_sys) begin
        hostSrc <= hostReq;
    end

    // pin wired to an interrupt input of the host
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hostIrqSeen <= 1'b0;
        end else begin
            hostIrqSeen <= host_irq_out_pin;
        end
    end
endmodule // irq_host_model

`default_nettype wire

// ==== bench/test_dual_interrupt_aggregator.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_dual_interrupt_aggregator;
    import irq_agg_pkg::*;

    logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, extResetReq, powerUp;
    logic lvlZero, lvlOne, edgeReq, coreLine, edgeMode, coreRst;
    logic levelReqZero, levelReqOne, edgeReqPulse, hostPin, pciN, irq;
    logic hostIrqSeen;
    logic [7:0]            awaddr, araddr;
    logic [31:0]           wdata, rdata;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    logic [DSP_SRC_N-1:0]  dspSrc;
    logic [HOST_SRC_N-1:0] hostReq, hostSrc;
    int                    mismatches, numChecks;

    dual_interrupt_aggregator dut (
        .clk_sys(clk_sys), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .dspSrc(dspSrc), .hostSrc(hostSrc), .extResetReq(extResetReq),
        .powerUp(powerUp), .ext_level_request_zero(lvlZero),
        .ext_level_request_one(lvlOne), .ext_edge_request(edgeReq),
        .shared_core_irq_line(coreLine), .coreIrqEdgeMode(edgeMode),
        .coreResetReq(coreRst), .levelReqZero(levelReqZero),
        .levelReqOne(levelReqOne), .edgeReqPulse(edgeReqPulse),
        .host_irq_out_pin(hostPin), .pci_irq_a_out_n(pciN), .irq(irq));

    irq_host_model host (
        .clk_sys(clk_sys), .rst(rst), .hostReq(hostReq), .hostSrc(hostSrc),
        .host_irq_out_pin(hostPin), .hostIrqSeen(hostIrqSeen));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------------------
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] resp);
        bit aw, w, b;
        int n;
        aw = 1;
        w = 1;
        b = 1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((aw || w || b) && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (aw && awready) begin
                aw = 0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 1'b0;
            end
            if (b && bvalid) begin
                b = 0;
                bready <= 1'b0;
                check({30'h0, bresp}, {30'h0, resp});
            end
        end
        if (aw || w || b) begin
            mismatches++;
            giveVerdict();
        end
        // let an edge pass so the next call does not re-raise bready at once
        tick(1);
    endtask

    task automatic axiRead(input logic [7:0] a, input logic [31:0] exp,
                           input logic [1:0] resp);
        bit ar, r;
        int n;
        ar = 1;
        r = 1;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while ((ar || r) && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (ar && arready) begin
                ar = 0;
                arvalid <= 1'b0;
            end
            if (r && rvalid) begin
                r = 0;
                rready <= 1'b0;
                check(rdata, exp);
                check({30'h0, rresp}, {30'h0, resp});
            end
        end
        if (ar || r) begin
            mismatches++;
            giveVerdict();
        end
        // let an edge pass so the next call does not re-raise rready at once
        tick(1);
    endtask

    task automatic bit1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int hi;
        mismatches = 0;
        numChecks = 0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {extResetReq, powerUp, lvlZero, lvlOne, edgeReq} = 5'h00;
        dspSrc = 9'h000;
        hostReq = 5'h00;
        rst = 1'b1;
        tick(6);
        rst <= 1'b0;
        tick(1);
        axiRead(DSP_MASK_OFS, 32'h0, RESP_OKAY);
        axiRead(HOST_MASK_OFS, 32'h0, RESP_OKAY);
        axiRead(CTRL_OFS, 32'h0, RESP_OKAY);
        bit1(pciN, 1'b1);
        $display("test reset done");

        dspSrc <= 9'h1FF;
        tick(5);
        bit1(coreLine, 1'b0);
        axiRead(DSP_RAW_OFS, 32'h1FF, RESP_OKAY);
        axiRead(DSP_MASKED_OFS, 32'h0, RESP_OKAY);
        axiWrite(DSP_MASK_OFS, 32'h101, 4'h3, RESP_OKAY);
        tick(5);
        axiRead(DSP_MASKED_OFS, 32'h101, RESP_OKAY);
        bit1(coreLine, 1'b1);
        axiWrite(DSP_MASK_OFS, 32'h0FE, 4'h1, RESP_OKAY);
        axiRead(DSP_MASK_OFS, 32'h1FE, RESP_OKAY);
        dspSrc <= 9'h001;
        tick(5);
        axiRead(DSP_MASKED_OFS, 32'h0, RESP_OKAY);
        bit1(coreLine, 1'b0);
        $display("test dsp side done");

        hostReq <= 5'h1F;
        tick(6);
        bit1(hostPin, 1'b0);
        axiWrite(HOST_MASK_OFS, 32'h04, 4'hF, RESP_OKAY);
        tick(5);
        axiRead(HOST_RAW_OFS, 32'h1F, RESP_OKAY);
        axiRead(HOST_MASKED_OFS, 32'h04, RESP_OKAY);
        bit1(hostPin, 1'b1);
        bit1(pciN, 1'b1);
        axiWrite(CTRL_OFS, 32'h4, 4'hF, RESP_OKAY);
        tick(5);
        bit1(pciN, 1'b0);
        bit1(hostIrqSeen, 1'b1);
        hostReq <= 5'h1B;
        tick(6);
        axiRead(HOST_MASKED_OFS, 32'h0, RESP_OKAY);
        bit1(hostPin, 1'b0);
        bit1(pciN, 1'b1);
        $display("test host side done");

        powerUp <= 1'b1;
        tick(5);
        bit1(coreRst, 1'b0);
        axiWrite(CTRL_OFS, 32'h3, 4'hF, RESP_OKAY);
        tick(5);
        bit1(coreRst, 1'b1);
        bit1(edgeMode, 1'b1);
        powerUp <= 1'b0;
        extResetReq <= 1'b1;
        lvlZero <= 1'b1;
        edgeReq <= 1'b1;
        hi = 0;
        repeat (8) begin
            @(posedge clk_sys);
            hi += int'(edgeReqPulse === 1'b1);
        end
        check(hi, 1);
        bit1(coreRst, 1'b1);
        bit1(levelReqZero, 1'b1);
        bit1(levelReqOne, 1'b0);
        $display("test core inputs done");

        axiRead(8'h40, 32'h0, RESP_SLVERR);
        axiWrite(8'h40, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
        axiRead(EVT_STAT_OFS, 32'h3, RESP_OKAY);
        bit1(irq, 1'b0);
        axiWrite(EVT_EN_OFS, 32'h2, 4'hF, RESP_OKAY);
        tick(2);
        bit1(irq, 1'b1);
        axiWrite(EVT_CLR_OFS, 32'h2, 4'hF, RESP_OKAY);
        tick(2);
        bit1(irq, 1'b0);
        axiRead(EVT_STAT_OFS, 32'h1, RESP_OKAY);
        $display("test events done");
        giveVerdict();
    end
endmodule // test_dual_interrupt_aggregator

`default_nettype wire

// ==== hdl/dual_interrupt_aggregator.sv ====
`timescale 1ns/100ps
`default_nettype none

module dual_interrupt_aggregator
    import irq_agg_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // axi4-lite write
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // axi4-lite read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // pending sources, asynchronous
    input  wire logic [DSP_SRC_N-1:0]  dspSrc,
    input  wire logic [HOST_SRC_N-1:0] hostSrc,
    input  wire logic                  extResetReq,
    input  wire logic                  powerUp,
    input  wire logic                  ext_level_request_zero,
    input  wire logic                  ext_level_request_one,
    input  wire logic                  ext_edge_request,
    // outputs
    output logic                       shared_core_irq_line,
    output logic                       coreIrqEdgeMode,
    output logic                       coreResetReq,
    output logic                       levelReqZero,
    output logic                       levelReqOne,
    output logic                       edgeReqPulse,
    output logic                       host_irq_out_pin,
    output logic                       pci_irq_a_out_n,
    output logic                       irq
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SYN_W = DSP_SRC_N + HOST_SRC_N + 5;
    logic [SYN_W-1:0] syn1_q;
    logic [SYN_W-1:0] syn2_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syn1_q <= '0;
            syn2_q <= '0;
        end else begin
            syn1_q <= {dspSrc, hostSrc, extResetReq, powerUp,
                       ext_level_request_zero, ext_level_request_one,
                       ext_edge_request};
            syn2_q <= syn1_q;
        end
    end

    logic [DSP_SRC_N-1:0]  dsp_raw_pending;
    logic [HOST_SRC_N-1:0] host_raw_pending;
    logic                  extRst;
    logic                  pwrUp;
    logic                  lvl0;
    logic                  lvl1;
    logic                  edgeIn;
    assign dsp_raw_pending  = syn2_q[SYN_W-1 -: DSP_SRC_N];
    assign host_raw_pending = syn2_q[HOST_SRC_N+4 : 5];
    assign extRst = syn2_q[4];
    assign pwrUp  = syn2_q[3];
    assign lvl0   = syn2_q[2];
    assign lvl1   = syn2_q[1];
    assign edgeIn = syn2_q[0];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [DSP_SRC_N-1:0]  dsp_source_mask_q;
    logic [HOST_SRC_N-1:0] host_source_mask_q;
    logic [2:0]            ctrl_q;
    logic [EVT_N-1:0]      evtStat_q;
    logic [EVT_N-1:0]      evtEn_q;
    logic                  wrFire;
    logic                  awHeld_q;
    logic                  wHeld_q;
    logic [7:0]            awAddr_q;
    logic [31:0]           wData_q;
    logic [3:0]            wStrb_q;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= EVT_EN_OFS) && (a[1:0] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // aggregation
    // ------------------------------------------------------------
    logic [DSP_SRC_N-1:0]  dsp_masked_pending;
    logic [HOST_SRC_N-1:0] host_masked_pending;
    assign dsp_masked_pending  = dsp_raw_pending & dsp_source_mask_q;
    assign host_masked_pending = host_raw_pending & host_source_mask_q;

    logic edgeDly_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shared_core_irq_line <= 1'b0;
            host_irq_out_pin     <= 1'b0;
            pci_irq_a_out_n      <= 1'b1;
            coreIrqEdgeMode      <= 1'b0;
            coreResetReq         <= 1'b0;
            levelReqZero         <= 1'b0;
            levelReqOne          <= 1'b0;
            edgeReqPulse         <= 1'b0;
            edgeDly_q            <= 1'b0;
        end else begin
            shared_core_irq_line <= |dsp_masked_pending;
            host_irq_out_pin     <= |host_masked_pending;
            pci_irq_a_out_n      <= ~(ctrl_q[CTRL_PCI_BIT]
                                      & (|host_masked_pending));
            coreIrqEdgeMode      <= ctrl_q[CTRL_EDGE_BIT];
            coreResetReq         <= extRst
                                  | (pwrUp & ctrl_q[CTRL_POWERUP_RESET_CTL_BIT]);
            levelReqZero         <= lvl0;
            levelReqOne          <= lvl1;
            edgeDly_q            <= edgeIn;
            edgeReqPulse         <= edgeIn & ~edgeDly_q;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign wrFire = awHeld_q && wHeld_q && !bvalid;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            awready <= !awHeld_q && !(awvalid && awready);
            wready  <= !wHeld_q && !(wvalid && wready);
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= is_mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dsp_source_mask_q  <= DSP_MASK_RST;
            host_source_mask_q <= HOST_MASK_RST;
            ctrl_q             <= CTRL_RST;
            evtEn_q            <= '0;
        end else if (wrFire) begin
            unique case (awAddr_q)
                DSP_MASK_OFS: begin
                    if (wStrb_q[0]) dsp_source_mask_q[7:0] <= wData_q[7:0];
                    if (wStrb_q[1]) dsp_source_mask_q[8] <= wData_q[8];
                end
                HOST_MASK_OFS: begin
                    if (wStrb_q[0]) host_source_mask_q <= wData_q[4:0];
                end
                CTRL_OFS: begin
                    if (wStrb_q[0]) ctrl_q <= wData_q[2:0];
                end
                EVT_EN_OFS: begin
                    if (wStrb_q[0]) evtEn_q <= wData_q[EVT_N-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sticky events: rise of either aggregated output
    // ------------------------------------------------------------
    logic [EVT_N-1:0] evtSet;
    logic [EVT_N-1:0] evtClr;
    logic [EVT_N-1:0] aggNow;
    logic [EVT_N-1:0] aggPrev_q;
    assign aggNow = {|host_masked_pending, |dsp_masked_pending};
    assign evtSet = aggNow & ~aggPrev_q;
    assign evtClr = (wrFire && awAddr_q == EVT_CLR_OFS && wStrb_q[0])
                  ? wData_q[EVT_N-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aggPrev_q <= '0;
            evtStat_q <= '0;
            irq       <= 1'b0;
        end else begin
            aggPrev_q <= aggNow;
            evtStat_q <= (evtStat_q & ~evtClr) | evtSet;
            irq       <= |(evtStat_q & evtEn_q);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        unique case (a)
            DSP_MASK_OFS:    read_mux = 32'(dsp_source_mask_q);
            DSP_RAW_OFS:     read_mux = 32'(dsp_raw_pending);
            DSP_MASKED_OFS:  read_mux = 32'(dsp_masked_pending);
            HOST_MASK_OFS:   read_mux = 32'(host_source_mask_q);
            HOST_RAW_OFS:    read_mux = 32'(host_raw_pending);
            HOST_MASKED_OFS: read_mux = 32'(host_masked_pending);
            CTRL_OFS:        read_mux = 32'(ctrl_q);
            EVT_STAT_OFS:    read_mux = 32'(evtStat_q);
            EVT_EN_OFS:      read_mux = 32'(evtEn_q);
            default:         read_mux = 32'h0000_0000;
        endcase
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= read_mux(araddr);
                rresp  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_dspPend;
        |(syn2_q[SYN_W-1 -: DSP_SRC_N] & dsp_source_mask_q);
    endsequence

    a_dsp_line_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_dspPend |=> shared_core_irq_line)
        else $error("core line not raised for enabled source");

    a_dsp_line_clr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (dsp_masked_pending == '0) |=> !shared_core_irq_line)
        else $error("core line raised with no enabled source");

    a_host_pin_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        (|(host_raw_pending & host_source_mask_q))
            |=> host_irq_out_pin)
        else $error("host pin not raised");

    a_host_pin_clr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (host_source_mask_q == '0) |=> !host_irq_out_pin)
        else $error("host pin raised while masked");

    // outputs must be the or of raw bits gated by the mask one cycle back
    a_masked_and: assert property (
        @(posedge clk_sys) disable iff (rst)
        shared_core_irq_line
            == |($past(dsp_raw_pending) & $past(dsp_source_mask_q))
        && host_irq_out_pin
            == |($past(host_raw_pending) & $past(host_source_mask_q)))
        else $error("aggregated output not or of masked bits");

    a_mask_reset: assert property (
        @(posedge clk_sys)
        $past(rst) |-> dsp_source_mask_q == '0
                       && host_source_mask_q == '0)
        else $error("masks not cleared by reset");

    a_pci_follow: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ctrl_q[CTRL_PCI_BIT] && |host_masked_pending)
            |=> !pci_irq_a_out_n)
        else $error("pci interrupt not asserted");

    a_reset_src: assert property (
        @(posedge clk_sys) disable iff (rst)
        (pwrUp && ctrl_q[CTRL_POWERUP_RESET_CTL_BIT]) |=> coreResetReq)
        else $error("power-up reset not raised");

    a_edge_pulse: assert property (
        @(posedge clk_sys) disable iff (rst)
        edgeReqPulse |=> !edgeReqPulse)
        else $error("edge request longer than one cycle");

    a_raw_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        (arvalid && arready && araddr == DSP_RAW_OFS)
            |=> rdata == 32'($past(dsp_raw_pending)))
        else $error("raw status read wrong");

endmodule // dual_interrupt_aggregator

`default_nettype wire

// ==== hdl/irq_agg_pkg.sv ====
`default_nettype none

package irq_agg_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DSP_MASK_OFS    = 8'h00;
    localparam logic [7:0] DSP_RAW_OFS     = 8'h04;
    localparam logic [7:0] DSP_MASKED_OFS  = 8'h08;
    localparam logic [7:0] HOST_MASK_OFS   = 8'h0C;
    localparam logic [7:0] HOST_RAW_OFS    = 8'h10;
    localparam logic [7:0] HOST_MASKED_OFS = 8'h14;
    localparam logic [7:0] CTRL_OFS        = 8'h18;
    localparam logic [7:0] EVT_STAT_OFS    = 8'h1C;
    localparam logic [7:0] EVT_CLR_OFS     = 8'h20;
    localparam logic [7:0] EVT_EN_OFS      = 8'h24;

    // ------------------------------------------------------------
    // widths and fields
    // ------------------------------------------------------------
    localparam int DSP_SRC_N  = 9;
    localparam int HOST_SRC_N = 5;
    localparam int CORE_SRC_N = 14;
    localparam int CORE_VEC_N = 12;
    localparam int CTRL_POWERUP_RESET_CTL_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_PCI_BIT  = 2;
    localparam int EVT_N = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DSP_SRC_N-1:0]  DSP_MASK_RST  = 9'h000;
    localparam logic [HOST_SRC_N-1:0] HOST_MASK_RST = 5'h00;
    localparam logic [2:0]            CTRL_RST      = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire
